//--- analog_array_digital_interface.v
`timescale 1ns/1ps
`include "analog_array_map.vh"
module analog_array_digital_interface (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire phase_one_clock,
  input wire phase_two_clock,
  input wire [3:0] ct_comp_raw,
  input wire [3:0] sc_comp_raw,
  output reg [3:0] comparator_latched,
  output reg [5:0] dac_code,
  output reg sc_write_strobe,
  output reg [7:0] sc_write_data,
  output reg [11:0] column_pin_sel,
  output wire irq
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_STALL = 3'b010;
  localparam [2:0] ST_RESP = 3'b100;

  // Two-stage synchronisers for all analog-side inputs
  reg [9:0] sync1_q, sync2_q;
  reg p1_prev_q, p2_prev_q;
  wire p1, p2, p1_rise, p2_fall;
  wire [3:0] ct_raw, sc_raw;

  reg [7:0] input_select_q;
  reg [3:0] irq_source_q;
  reg [3:0] sync_ctrl_q;
  reg [1:0] swap_q;
  reg [15:0] cmp_source_q;
  reg [4:0] irq_status_q, irq_mask_q;
  reg [2:0] sar_count_q;
  reg [3:0] ct_blk_q, sc_blk_q, comp_prev_q;

  reg [2:0] state_q;
  reg aw_have_q, w_have_q;
  reg [11:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire [3:0] src_sc, ct_en, ct_phase, sc_phase, ct_gate, sc_gate, col_bus, events;
  wire sync_en, sar_sign, sar_cmp, stall_target, both, commit, wmapped, lane0, sar_step, sar_done;
  wire [1:0] sar_col;
  wire [4:0] irq_clear, irq_set;
  reg [5:0] dac_step;
  reg [2:0] sar_pos;
  reg [31:0] rd_mux;
  reg rd_hit;
  integer i;

  assign p1 = sync2_q[9];
  assign p2 = sync2_q[8];
  assign ct_raw = sync2_q[7:4];
  assign sc_raw = sync2_q[3:0];
  assign p1_rise = p1 & ~p1_prev_q;
  assign p2_fall = p2_prev_q & ~p2;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
      p1_prev_q <= 1'b0;
      p2_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {phase_one_clock, phase_two_clock, ct_comp_raw, sc_comp_raw};
      sync2_q <= sync1_q;
      p1_prev_q <= p1;
      p2_prev_q <= p2;
    end
  end

  assign src_sc = cmp_source_q[3:0];
  assign ct_en = cmp_source_q[7:4];
  assign ct_phase = cmp_source_q[11:8];
  assign sc_phase = cmp_source_q[15:12];
  // A phase bit of 1 latches on phase two, 0 on phase one
  assign ct_gate = ({4{p2}} & ct_phase) | ({4{p1}} & ~ct_phase); // RULE_06
  assign sc_gate = ({4{p2}} & sc_phase) | ({4{p1}} & ~sc_phase); // RULE_07
  // Exactly one block drives each column bus
  assign col_bus = (src_sc & sc_blk_q) | (~src_sc & ((ct_en & ct_blk_q) | (~ct_en & ct_raw))); // RULE_01

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ct_blk_q <= 4'h0;
      sc_blk_q <= 4'h0;
      comparator_latched <= 4'h0;
      comp_prev_q <= 4'h0;
    end
    else
    begin
      ct_blk_q <= (ct_gate & ct_raw) | (~ct_gate & ct_blk_q); // RULE_06
      sc_blk_q <= (sc_gate & sc_raw) | (~sc_gate & sc_blk_q); // RULE_07
      // Holds its value while phase two is low
      if (p2)
      begin
        comparator_latched <= col_bus; // RULE_02 RULE_03
      end
      comp_prev_q <= comparator_latched;
    end
  end

  // Interrupt events per column
  assign events = (~irq_source_q & comparator_latched & ~comp_prev_q) | (irq_source_q & {4{p2_fall}}); // RULE_05

  assign sync_en = sync_ctrl_q[`SYNC_EN_BIT];
  assign sar_sign = sync_ctrl_q[`SAR_SIGN_BIT];
  assign sar_col = sync_ctrl_q[`SAR_COL_LSB+1:`SAR_COL_LSB];
  assign sar_cmp = comparator_latched[sar_col] ^ sar_sign; // RULE_13 RULE_14

  // Write channel
  assign s_axi_awready = (state_q == ST_IDLE) & ~aw_have_q;
  assign s_axi_wready = (state_q == ST_IDLE) & ~w_have_q;
  assign s_axi_bvalid = (state_q == ST_RESP);
  assign both = aw_have_q & w_have_q;
  assign stall_target = (waddr_q == `ADDR_SC_WRITE) | (waddr_q == `ADDR_DAC) | (waddr_q == `ADDR_DAC_OR);
  assign commit = ((state_q == ST_IDLE) & both & ~(stall_target & sync_en)) | ((state_q == ST_STALL) & p1_rise);
  assign lane0 = wstrb_q[0];
  assign wmapped = (waddr_q == `ADDR_INPUT_SELECT) | (waddr_q == `ADDR_CMP_STATUS)
    | (waddr_q == `ADDR_SYNC_SAR) | (waddr_q == `ADDR_OUT_BUF) | stall_target
    | (waddr_q == `ADDR_IRQ_STATUS) | (waddr_q == `ADDR_IRQ_MASK) | (waddr_q == `ADDR_CMP_SOURCE);
  assign sar_step = commit & lane0 & (waddr_q == `ADDR_DAC_OR) & (sar_count_q != 3'h0);
  assign sar_done = sar_step & (sar_count_q == 3'h1); // RULE_11
  assign irq_set = {sar_done, events};
  assign irq_clear = (commit & lane0 & (waddr_q == `ADDR_IRQ_STATUS)) ? wdata_q[4:0] : 5'h00;
  assign irq = |(irq_status_q & irq_mask_q);

  // Successive-approximation step on the current guess bit
  always @*
  begin
    sar_pos = sar_count_q - 3'h1;
    dac_step = dac_code;
    for (i = 0; i < `SAR_WIDTH; i = i + 1)
    begin
      if ((i == sar_pos) && !sar_cmp)
      begin
        dac_step[i] = 1'b0; // RULE_10
      end
      if ((i + 1) == sar_pos)
      begin
        dac_step[i] = 1'b1; // RULE_10
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (commit)
      begin
        s_axi_bresp <= wmapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      case (state_q)
        ST_IDLE:
        begin
          if (both)
          begin
            state_q <= commit ? ST_RESP : ST_STALL; // RULE_08
          end
        end
        ST_STALL:
        begin
          if (p1_rise)
          begin
            state_q <= ST_RESP; // RULE_08
          end
        end
        ST_RESP:
        begin
          if (s_axi_bready)
          begin
            state_q <= ST_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Register file updates
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      input_select_q <= `RST_BYTE;
      irq_source_q <= 4'h0;
      sync_ctrl_q <= 4'h0;
      sar_count_q <= 3'h0;
      swap_q <= 2'h0;
      cmp_source_q <= `RST_SOURCE;
      irq_mask_q <= `RST_IRQ;
      irq_status_q <= `RST_IRQ;
      dac_code <= `RST_DAC;
      sc_write_strobe <= 1'b0;
      sc_write_data <= `RST_BYTE;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_set;
      sc_write_strobe <= 1'b0;
      if (commit && lane0)
      begin
        if (waddr_q == `ADDR_INPUT_SELECT)
        begin
          input_select_q <= wdata_q[7:0]; // RULE_17
        end
        else if (waddr_q == `ADDR_CMP_STATUS)
        begin
          irq_source_q <= wdata_q[3:0]; // RULE_19
        end
        else if (waddr_q == `ADDR_SYNC_SAR)
        begin
          sync_ctrl_q <= wdata_q[3:0];
          sar_count_q <= wdata_q[`SAR_COUNT_LSB+2:`SAR_COUNT_LSB]; // RULE_12
        end
        else if (waddr_q == `ADDR_OUT_BUF)
        begin
          swap_q <= {wdata_q[`SWAP1_BIT], wdata_q[`SWAP2_BIT]}; // RULE_18
        end
        else if (waddr_q == `ADDR_DAC)
        begin
          dac_code <= wdata_q[5:0];
        end
        else if (waddr_q == `ADDR_DAC_OR)
        begin
          if (sar_count_q != 3'h0)
          begin
            dac_code <= dac_step; // RULE_10
            sar_count_q <= sar_count_q - 3'h1; // RULE_11
          end
          else
          begin
            dac_code <= dac_code | wdata_q[5:0];
          end
        end
        else if (waddr_q == `ADDR_SC_WRITE)
        begin
          sc_write_strobe <= 1'b1; // RULE_08
          sc_write_data <= wdata_q[7:0];
        end
        else if (waddr_q == `ADDR_IRQ_MASK)
        begin
          irq_mask_q <= wdata_q[4:0];
        end
        else if (waddr_q == `ADDR_CMP_SOURCE)
        begin
          cmp_source_q[7:0] <= wdata_q[7:0];
        end
      end
      if (commit && wstrb_q[1] && (waddr_q == `ADDR_CMP_SOURCE))
      begin
        cmp_source_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Column pin selection, col3 in [11:9] down to col0 in [2:0]
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      column_pin_sel <= 12'h000;
    end
    else
    begin
      column_pin_sel[11:9] <= {input_select_q[7:6], 1'b0}; // RULE_17
      column_pin_sel[8:6] <= swap_q[0] ? {input_select_q[7:6], 1'b0} : {input_select_q[5:4], 1'b1}; // RULE_18
      column_pin_sel[5:3] <= swap_q[1] ? {input_select_q[1:0], 1'b1} : {input_select_q[3:2], 1'b0}; // RULE_18
      column_pin_sel[2:0] <= {input_select_q[1:0], 1'b1}; // RULE_17
    end
  end

  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `ADDR_INPUT_SELECT)
    begin
      rd_mux[7:0] = input_select_q;
    end
    else if (s_axi_araddr == `ADDR_CMP_STATUS)
    begin
      rd_mux[7:0] = {comparator_latched, irq_source_q}; // RULE_04
    end
    else if (s_axi_araddr == `ADDR_SYNC_SAR)
    begin
      rd_mux[3:0] = sync_ctrl_q;
    end
    else if (s_axi_araddr == `ADDR_DAC)
    begin
      rd_mux[5:0] = dac_code; // RULE_11
    end
    else if (s_axi_araddr == `ADDR_DAC_OR)
    begin
      rd_mux[5:0] = dac_code;
    end
    else if (s_axi_araddr == `ADDR_IRQ_STATUS)
    begin
      rd_mux[4:0] = irq_status_q;
    end
    else if (s_axi_araddr == `ADDR_IRQ_MASK)
    begin
      rd_mux[4:0] = irq_mask_q;
    end
    else if (s_axi_araddr == `ADDR_CMP_SOURCE)
    begin
      rd_mux[15:0] = cmp_source_q;
    end
    else if ((s_axi_araddr == `ADDR_OUT_BUF) || (s_axi_araddr == `ADDR_SC_WRITE))
    begin
      rd_mux = 32'h00000000;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // analog_array_digital_interface

//--- analog_array_digital_interface_assertions.sv
`timescale 1ns/1ps
module analog_array_digital_interface_assertions (
  input wire aclk,
  input wire aresetn,
  input wire phase_two_clock,
  input wire [3:0] comparator_latched,
  input wire sc_write_strobe,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] dac_code,
  input wire [11:0] column_pin_sel,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_latch_hold;
    !phase_two_clock [*5] |-> $stable(comparator_latched);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
  property p_sc_pulse;
    sc_write_strobe |-> s_axi_bvalid ##1 !sc_write_strobe;
  endproperty
  a_sc_pulse: assert property (p_sc_pulse) else $error("bad sc strobe");
  property p_dac_by_write;
    $changed(dac_code) |-> $rose(s_axi_bvalid);
  endproperty
  a_dac_by_write: assert property (p_dac_by_write) else $error("dac moved alone");
  property p_col3_even;
    column_pin_sel[9] == 1'b0;
  endproperty
  a_col3_even: assert property (p_col3_even) else $error("odd pin on col3");
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("late read");
  property p_rdrop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdrop: assert property (p_rdrop) else $error("rvalid held");
  property p_bdrop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdrop: assert property (p_bdrop) else $error("bvalid held");
  property p_arready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_arready: assert property (p_arready) else $error("arready wrong");
endmodule // analog_array_digital_interface_assertions

//--- analog_array_map.vh
// Overview of operation
// [RULE_01] One driver per column comparator bus
// [RULE_02] Column latch follows bus while phase two high
// [RULE_03] Latch holds value at phase two fall
// [RULE_04] Latched comparators read in bits 7..4
// [RULE_05] Irq source: comparator bus or phase-two fall
// [RULE_06] Continuous-time latch enable and phase bits
// [RULE_07] Switched-cap output always latched, phase selectable
// [RULE_08] Sync enable stalls switched-cap writes until phase one
// [RULE_09] Firmware initialises control, then sets sign guess
// [RULE_10] Each OR access checks guess, sets next bit
// [RULE_11] Six OR accesses finish six-bit conversion
// [RULE_12] Write-only bits 6..4 load bit count
// [RULE_13] Bit 3 inverts comparator sense for sequencer
// [RULE_14] Bits 2..1 pick sequencer comparator column
// [RULE_15] Column clock not power-of-two above processor clock
// [RULE_16] Other clock ratios never lock the stall
// [RULE_17] Two-bit pin select per column, even/odd pins
// [RULE_18] Columns 1 and 2 may take neighbour mux
// [RULE_19] Writes to status bits ignored
`ifndef ANALOG_ARRAY_MAP_VH
`define ANALOG_ARRAY_MAP_VH
`define IDX_INPUT_SELECT 12'h060
`define IDX_CMP_STATUS 12'h064
`define IDX_SYNC_SAR 12'h065
`define IDX_OUT_BUF 12'h062
`define IDX_DAC 12'h068
`define IDX_DAC_OR 12'h069
`define IDX_SC_WRITE 12'h06A
`define IDX_IRQ_STATUS 12'h06B
`define IDX_IRQ_MASK 12'h06C
`define IDX_CMP_SOURCE 12'h06D
`define ADDR_INPUT_SELECT 12'h180
`define ADDR_CMP_STATUS 12'h190
`define ADDR_SYNC_SAR 12'h194
`define ADDR_OUT_BUF 12'h188
`define ADDR_DAC 12'h1A0
`define ADDR_DAC_OR 12'h1A4
`define ADDR_SC_WRITE 12'h1A8
`define ADDR_IRQ_STATUS 12'h1AC
`define ADDR_IRQ_MASK 12'h1B0
`define ADDR_CMP_SOURCE 12'h1B4
`define RST_BYTE 8'h00
`define RST_SOURCE 16'h0000
`define RST_IRQ 5'h00
`define RST_DAC 6'h00
`define SAR_WIDTH 6
`define SYNC_EN_BIT 0
`define SAR_COL_LSB 1
`define SAR_SIGN_BIT 3
`define SAR_COUNT_LSB 4
`define SWAP1_BIT 7
`define SWAP2_BIT 6
`define IRQ_SAR_DONE_BIT 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- analog_column_model.sv
`timescale 1ns/1ps
module analog_column_model (
  input wire aclk,
  input wire [3:0] ct_val,
  input wire sar_on,
  input wire [1:0] sar_col,
  input wire sar_inv,
  input wire [5:0] target,
  input wire [5:0] dac_code,
  output wire phase_one_clock,
  output wire phase_two_clock,
  output reg [3:0] ct_comp_raw,
  output wire [3:0] sc_comp_raw
);
  reg [3:0] cnt_q = 4'h0;
  // Column clock at aclk/16, phases never overlap
  always @(posedge aclk)
    cnt_q <= cnt_q + 4'h1;
  assign phase_one_clock = cnt_q < 4'h4;
  assign phase_two_clock = cnt_q[3] && !cnt_q[2];
  // A CT and an SC block per column; the sar_col column compares DAC with its input
  always @*
  begin
    ct_comp_raw = ct_val;
    if (sar_on)
      ct_comp_raw[sar_col] = (dac_code <= target) ^ sar_inv;
  end
  assign sc_comp_raw = ~ct_val;
endmodule // analog_column_model

//--- tb_analog_array_digital_interface.sv
`timescale 1ns/1ps
module tb_analog_array_digital_interface;
  reg aclk;
  reg aresetn = 1'b0;
  reg [11:0] awaddr = 12'h000;
  reg [11:0] araddr = 12'h000;
  reg [31:0] wdata = 32'h00000000;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b1;
  reg arvalid = 1'b0;
  reg rready = 1'b1;
  reg [3:0] ct_val = 4'h0;
  reg sar_on = 1'b0;
  reg sar_inv = 1'b0;
  reg [1:0] sar_col = 2'h0;
  reg [5:0] target = 6'h00;
  reg [7:0] sc_seen = 8'h00;
  wire awready, wready, bvalid, arready, rvalid, irq, sc_strobe, p1, p2;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] ct_raw, sc_raw, latched;
  wire [5:0] dac;
  wire [7:0] sc_data;
  wire [11:0] pins;
  integer miscompares = 0;
  integer n_checks = 0;
  integer lat;
  reg [31:0] rd;
  reg [1:0] rs;
  analog_array_digital_interface DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_one_clock(p1), .phase_two_clock(p2), .ct_comp_raw(ct_raw), .sc_comp_raw(sc_raw),
    .comparator_latched(latched), .dac_code(dac), .sc_write_strobe(sc_strobe),
    .sc_write_data(sc_data), .column_pin_sel(pins), .irq(irq));
  analog_column_model partner (.aclk(aclk), .ct_val(ct_val), .sar_on(sar_on),
    .sar_col(sar_col), .sar_inv(sar_inv), .target(target), .dac_code(dac),
    .phase_one_clock(p1), .phase_two_clock(p2), .ct_comp_raw(ct_raw), .sc_comp_raw(sc_raw));
  always @(posedge aclk)
  begin
    if (sc_strobe)
      sc_seen <= sc_data;
  end
  task chk(input string what, input [31:0] seen, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  end
  endtask
  task close_out;
  begin
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task guard(input ok);
  begin
    if (!ok)
    begin
      chk("wait", 0, 1);
      close_out;
    end
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    integer i;
  begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 300 && (i == 0 || !bvalid); i = i + 1)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    lat = i;
    guard(i < 300);
  end
  endtask
  task rdr(input [11:0] a);
    integer i;
  begin
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 300 && (i == 0 || !rvalid); i = i + 1)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    rd = rdata;
    rs = rresp;
    guard(i < 300);
  end
  endtask
  // Returns at the first edge where the chosen phase reaches lvl after leaving it
  task ph(input one, input lvl);
    integer i;
    reg seen;
  begin
    seen = 1'b0;
    for (i = 0; i < 64 && !(seen && (one ? p1 : p2) == lvl); i = i + 1)
    begin
      @(posedge aclk);
      if ((one ? p1 : p2) != lvl)
        seen = 1'b1;
    end
    guard(i < 64);
  end
  endtask
  task t_regs;
    integer k;
    reg [35:0] adr;
  begin
    adr = {12'h180, 12'h190, 12'h194};
    for (k = 0; k < 3; k = k + 1)
    begin
      rdr(adr[k * 12 +: 12]);
      chk("reset", rd, 32'h00000000);
    end
    rdr(12'h1FC);
    chk("unmapped", rs, 2'h2);
    wr(12'h1FC, 32'h00);
    chk("unmapped wr", bresp, 2'h2);
    $display("regs done");
  end
  endtask
  task t_pins;
  begin
    wr(12'h180, 32'hE4);
    @(posedge aclk);
    chk("pins", pins, 12'hD51);
    wr(12'h180, 32'h1B);
    @(posedge aclk);
    chk("pins", pins, 12'h0E7);
    wr(12'h188, 32'hC0);
    @(posedge aclk);
    chk("swap", pins, 12'h03F);
    rdr(12'h180);
    chk("sel", rd, 32'h1B);
    $display("pins done");
  end
  endtask
  task t_latch;
  begin
    ct_val <= 4'hA;
    repeat (2) ph(1'b0, 1'b0);
    chk("latched", latched, 4'hA);
    ph(1'b1, 1'b0);
    ct_val <= 4'h5;
    ph(1'b0, 1'b1);
    chk("held", latched, 4'hA);
    ph(1'b0, 1'b0);
    chk("follows", latched, 4'h5);
    wr(12'h190, 32'hFF);
    rdr(12'h190);
    chk("status", rd, 32'h5F);
    wr(12'h190, 32'h00);
    wr(12'h1B4, 32'h0F);
    repeat (2) ph(1'b0, 1'b0);
    chk("sc bus", latched, 4'hA);
    wr(12'h1B4, 32'h00);
    $display("latch done");
  end
  endtask
  task t_irq;
  begin
    repeat (2) ph(1'b0, 1'b0);
    wr(12'h1AC, 32'h1F);
    wr(12'h1B0, 32'h01);
    wr(12'h190, 32'h01);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b1);
    chk("irq", irq, 1'b1);
    wr(12'h1B0, 32'h00);
    chk("masked", irq, 1'b0);
    wr(12'h190, 32'h00);
    wr(12'h1AC, 32'h1F);
    ct_val <= 4'h7;
    repeat (2) ph(1'b0, 1'b0);
    rdr(12'h1AC);
    chk("bus event", rd, 32'h02);
    wr(12'h1AC, 32'h1F);
    $display("irq done");
  end
  endtask
  task t_sar(input [1:0] col, input inv, input [5:0] tgt);
    integer k;
  begin
    ct_val <= 4'h0;
    sar_on <= 1'b1;
    sar_col <= col;
    sar_inv <= inv;
    target <= tgt;
    wr(12'h194, {25'h0, 3'h6, inv, col, 1'b0});
    wr(12'h1A0, 32'h20);
    for (k = 0; k < 6; k = k + 1)
    begin
      repeat (2) ph(1'b0, 1'b0);
      wr(12'h1A4, 32'h00);
    end
    chk("dac", dac, tgt);
    rdr(12'h1A0);
    chk("dac read", rd, tgt);
    rdr(12'h194);
    chk("ctrl", rd, {inv, col, 1'b0});
    rdr(12'h1AC);
    chk("done", rd[4], 1'b1);
    wr(12'h1AC, 32'h1F);
    sar_on <= 1'b0;
    $display("sar done");
  end
  endtask
  task t_stall;
  begin
    wr(12'h194, 32'h01);
    ph(1'b1, 1'b0);
    wr(12'h1A8, 32'h5A);
    chk("stalled", lat > 8, 1'b1);
    wr(12'h194, 32'h00);
    chk("sc data", sc_seen, 8'h5A);
    ph(1'b1, 1'b0);
    wr(12'h1A8, 32'h3C);
    chk("free", lat < 6, 1'b1);
    @(posedge aclk);
    chk("sc data", sc_seen, 8'h3C);
    $display("stall done");
  end
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pins;
    t_latch;
    t_irq;
    t_sar(2'h0, 1'b0, 6'h2B);
    t_sar(2'h2, 1'b1, 6'h14);
    t_stall;
    close_out;
  end
endmodule // tb_analog_array_digital_interface
bind analog_array_digital_interface analog_array_digital_interface_assertions chk_u (.aclk(aclk),
  .aresetn(aresetn), .phase_two_clock(phase_two_clock), .comparator_latched(comparator_latched),
  .sc_write_strobe(sc_write_strobe), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .dac_code(dac_code), .column_pin_sel(column_pin_sel), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
